// [design/viep_cfg.svh]
// Offsets, field positions, reset values and vectors of the interrupt block
`ifndef VIEP_CFG_SVH
`define VIEP_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define VIEP_ADDR_EN_MAIN 8'ha8
`define VIEP_ADDR_EN_EXTRA 8'hb1
`define VIEP_ADDR_PRIO_HI 8'hb7
`define VIEP_ADDR_PRIO_LO 8'hb8
`define VIEP_ADDR_EVT_STS 8'he1
`define VIEP_ADDR_EVT_MSK 8'he2

// ----------------------------------------------------------------
// Bit-access pages (bit address bits 7:3)
// ----------------------------------------------------------------
`define VIEP_BITPG_EN_MAIN 5'h15
`define VIEP_BITPG_PRIO_LO 5'h17

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VIEP_GLOBAL_IRQ_GATE 7
`define VIEP_COUNTER_ARRAY_BIT 6
`define VIEP_TIMER2_BIT 5
`define VIEP_SERIAL_BIT 4
`define VIEP_TIMER1_BIT 3
`define VIEP_EXT1_BIT 2
`define VIEP_TIMER0_BIT 1
`define VIEP_EXT0_BIT 0
`define VIEP_SPI_IRQ_ON 2
`define VIEP_KEYPAD_IRQ_ON 0
`define VIEP_EVT_DISPATCH 0
`define VIEP_EVT_PREEMPT 1
`define VIEP_EVT_STRAY_RET 2

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define VIEP_RST_EN_MAIN 8'h00
`define VIEP_RST_EN_EXTRA 8'h00
`define VIEP_RST_PRIO 8'h00
`define VIEP_RST_EVT 8'h00
`define VIEP_WMSK_EN_EXTRA 8'h05
`define VIEP_WMSK_PRIO 8'h7f
`define VIEP_WMSK_EVT 8'h07

// ----------------------------------------------------------------
// Vector addresses
// ----------------------------------------------------------------
`define VIEP_VEC_RESET 16'h0000
`define VIEP_VEC_EXT0 16'h0003
`define VIEP_VEC_TIMER0 16'h000b
`define VIEP_VEC_EXT1 16'h0013
`define VIEP_VEC_TIMER1 16'h001b
`define VIEP_VEC_SERIAL 16'h0023
`define VIEP_VEC_TIMER2 16'h002b
`define VIEP_VEC_COUNTER 16'h0033
`define VIEP_VEC_KEYPAD 16'h003b
`define VIEP_VEC_UNUSED 16'h0043
`define VIEP_VEC_SPI 16'h004b

`endif

// [design/viep_pkg.sv]
// Types shared by the interrupt enable and priority block
package viep_pkg;

  // Priority level, 0 lowest, 3 highest
  typedef logic [1:0] viep_level_t;

  // Sources in polling order, first entry polled first
  typedef enum logic [3:0] {
    VIEP_SRC_EXT0 = 4'h0,
    VIEP_SRC_TIMER0 = 4'h1,
    VIEP_SRC_EXT1 = 4'h2,
    VIEP_SRC_TIMER1 = 4'h3,
    VIEP_SRC_COUNTER = 4'h4,
    VIEP_SRC_SERIAL = 4'h5,
    VIEP_SRC_TIMER2 = 4'h6,
    VIEP_SRC_KEYPAD = 4'h7,
    VIEP_SRC_UNUSED = 4'h8,
    VIEP_SRC_SPI = 4'h9
  } viep_src_t;

endpackage : viep_pkg

// [design/viep_src_cell.sv]
// One interrupt source: flag merge, enable gating, level and eligibility
`timescale 1ns/1ps
module viep_src_cell
  import viep_pkg::*;
#(
  parameter int NFLAG = 6
) (
  // Request flags of this source
  input wire logic [NFLAG-1:0] flags,
  // Enables
  input wire logic srcOn,
  input wire logic gateOn,
  // Priority bit pair
  input wire logic prioHi,
  input wire logic prioLo,
  // Service state after this cycle
  input wire logic busy,
  input wire viep_level_t topLvl,
  // Results
  output logic active,
  output logic eligible,
  output viep_level_t level
);

  // Any flag raises the request; gate and own enable must both be set
  assign active = (|flags) & srcOn & gateOn;
  // Level from high bit then low bit
  assign level = {prioHi, prioLo};
  // Only a strictly higher level may preempt the one in service
  assign eligible = active & (~busy | (level > topLvl));

endmodule : viep_src_cell

// [design/viep_ctrl.sv]
// Interrupt enable, priority ranking and vector selection for the core
//
// Functional notes
// [RULE_01] Reset vector 0000h; ext0,t0,ext1,t1,serial,timer2 vectors 03h to 2Bh.
// [RULE_02] Counter array at 33h, keypad 3Bh, SPI 4Bh; 43h has no source.
// [RULE_03] Equal levels resolve by fixed poll order, counter array before serial.
// [RULE_04] Global gate bit 7 clear blocks all; set lets each enable rule.
// [RULE_05] Main enable bits 6..0: counter,timer2,serial,timer1,ext1,timer0,ext0.
// [RULE_06] Extra enable: SPI at bit 2, keypad at bit 0, others reserved.
// [RULE_07] Level is high bit then low bit, 00 lowest, 11 highest.
// [RULE_08] Low and high priority registers share the main enable layout.
// [RULE_09] Software never sets reserved priority bits; their read is free.
// [RULE_10] Main enable resets to zero and allows single-bit access.
// [RULE_11] Low priority resets bits 6..0 to zero, bit-accessible.
// [RULE_12] High priority resets bits 6..0 to zero, byte access only.
// [RULE_13] Service preempted only by strictly higher level; level 3 never.
// [RULE_14] Higher level wins among simultaneous requests, then poll order.
// [RULE_15] Track levels in service, release the top one on return.
`timescale 1ns/1ps
`include "viep_cfg.svh"
module viep_ctrl
  import viep_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Byte register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRData,
  // Single-bit register port
  input wire logic [7:0] bitAddr,
  input wire logic bitWData,
  input wire logic bitWr,
  input wire logic bitRd,
  output logic bitRData,
  // Peripheral request flags
  input wire logic ext0RequestFlag,
  input wire logic timer0OverflowFlag,
  input wire logic ext1RequestFlag,
  input wire logic timer1OverflowFlag,
  input wire logic uartReceiveDone,
  input wire logic uartSendDone,
  input wire logic timer2OverflowFlag,
  input wire logic timer2ExternalFlag,
  input wire logic counterArrayOverflow,
  input wire logic [4:0] counterChannelFlags,
  input wire logic keypadRequest,
  input wire logic spiRequest,
  // Core vector handshake
  output logic irqReq,
  output logic [15:0] irqVector,
  output viep_level_t irqLevel,
  input wire logic irqAck,
  input wire logic irqReturn,
  // Event interrupt
  output logic evtIrq
);

  localparam int NSRC = 10;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] enMain_r;
  logic [7:0] enExtra_r;
  logic [7:0] prioHi_r;
  logic [7:0] prioLo_r;
  logic [7:0] evtSts_r;
  logic [7:0] evtMsk_r;
  logic [7:0] regRData_r;
  logic bitRData_r;
  logic [3:0] inSvc_r;
  logic irqReq_r;
  logic [15:0] irqVector_r;
  viep_level_t irqLevel_r;

  logic bitWrMain;
  logic bitWrLo;
  logic [2:0] bitIdx;

  // Bit access reaches only the two bit-accessible registers
  assign bitIdx = bitAddr[2:0];
  assign bitWrMain = bitWr & (bitAddr[7:3] == `VIEP_BITPG_EN_MAIN); // RULE_10
  assign bitWrLo = bitWr & (bitAddr[7:3] == `VIEP_BITPG_PRIO_LO); // RULE_11

  // Main enable: byte and single-bit writes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      enMain_r <= `VIEP_RST_EN_MAIN; // RULE_10
    end else if (regWr && regAddr == `VIEP_ADDR_EN_MAIN) begin
      enMain_r <= regWData;
    end else if (bitWrMain) begin
      enMain_r[bitIdx] <= bitWData; // RULE_10
    end
  end

  // Extra enable: only the SPI and keypad bits are kept
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      enExtra_r <= `VIEP_RST_EN_EXTRA;
    end else if (regWr && regAddr == `VIEP_ADDR_EN_EXTRA) begin
      enExtra_r <= regWData & `VIEP_WMSK_EN_EXTRA; // RULE_06
    end
  end

  // High priority: byte writes only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prioHi_r <= `VIEP_RST_PRIO; // RULE_12
    end else if (regWr && regAddr == `VIEP_ADDR_PRIO_HI) begin
      prioHi_r <= regWData & `VIEP_WMSK_PRIO; // RULE_12
    end
  end

  // Low priority: byte and single-bit writes, bit 7 not stored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prioLo_r <= `VIEP_RST_PRIO; // RULE_11
    end else if (regWr && regAddr == `VIEP_ADDR_PRIO_LO) begin
      prioLo_r <= regWData & `VIEP_WMSK_PRIO;
    end else if (bitWrLo && bitIdx != 3'h7) begin
      prioLo_r[bitIdx] <= bitWData; // RULE_11
    end
  end

  // ----------------------------------------------------------------
  // Sources in polling order
  // ----------------------------------------------------------------
  logic [5:0] srcFlags [NSRC];
  logic [NSRC-1:0] srcOn;
  logic [NSRC-1:0] srcHi;
  logic [NSRC-1:0] srcLo;
  logic [NSRC-1:0] srcActive;
  logic [NSRC-1:0] srcElig;
  viep_level_t srcLvl [NSRC];
  logic [3:0] inSvcNxt;
  logic busyNxt;
  viep_level_t topNxt;

  // Request merge per source; serial, timer 2, counter array are ORed
  always_comb begin
    srcFlags[0] = {5'h00, ext0RequestFlag};
    srcFlags[1] = {5'h00, timer0OverflowFlag};
    srcFlags[2] = {5'h00, ext1RequestFlag};
    srcFlags[3] = {5'h00, timer1OverflowFlag};
    srcFlags[4] = {counterChannelFlags, counterArrayOverflow}; // RULE_02
    srcFlags[5] = {4'h0, uartSendDone, uartReceiveDone}; // RULE_01
    srcFlags[6] = {4'h0, timer2ExternalFlag, timer2OverflowFlag}; // RULE_01
    srcFlags[7] = {5'h00, keypadRequest};
    srcFlags[8] = 6'h00;
    srcFlags[9] = {5'h00, spiRequest};
  end

  // Enables and priority bits mapped into polling order
  always_comb begin
    srcOn = {enExtra_r[`VIEP_SPI_IRQ_ON], 1'b0,
             enExtra_r[`VIEP_KEYPAD_IRQ_ON], // RULE_06
             enMain_r[`VIEP_TIMER2_BIT], enMain_r[`VIEP_SERIAL_BIT],
             enMain_r[`VIEP_COUNTER_ARRAY_BIT], enMain_r[`VIEP_TIMER1_BIT],
             enMain_r[`VIEP_EXT1_BIT], enMain_r[`VIEP_TIMER0_BIT],
             enMain_r[`VIEP_EXT0_BIT]}; // RULE_05
    srcHi = {3'h0, prioHi_r[`VIEP_TIMER2_BIT], prioHi_r[`VIEP_SERIAL_BIT],
             prioHi_r[`VIEP_COUNTER_ARRAY_BIT], prioHi_r[`VIEP_TIMER1_BIT],
             prioHi_r[`VIEP_EXT1_BIT], prioHi_r[`VIEP_TIMER0_BIT],
             prioHi_r[`VIEP_EXT0_BIT]}; // RULE_08
    srcLo = {3'h0, prioLo_r[`VIEP_TIMER2_BIT], prioLo_r[`VIEP_SERIAL_BIT],
             prioLo_r[`VIEP_COUNTER_ARRAY_BIT], prioLo_r[`VIEP_TIMER1_BIT],
             prioLo_r[`VIEP_EXT1_BIT], prioLo_r[`VIEP_TIMER0_BIT],
             prioLo_r[`VIEP_EXT0_BIT]}; // RULE_08
  end

  // One gating cell per source
  for (genvar g = 0; g < NSRC; g++) begin : gSrc
    viep_src_cell #(.NFLAG(6)) uCell (
      .flags(srcFlags[g]),
      .srcOn(srcOn[g]),
      .gateOn(enMain_r[`VIEP_GLOBAL_IRQ_GATE]), // RULE_04
      .prioHi(srcHi[g]), // RULE_07
      .prioLo(srcLo[g]),
      .busy(busyNxt), // RULE_13
      .topLvl(topNxt),
      .active(srcActive[g]),
      .eligible(srcElig[g]),
      .level(srcLvl[g])
    );
  end

  // ----------------------------------------------------------------
  // Service tracking
  // ----------------------------------------------------------------
  logic ackTake;
  logic retTake;
  viep_level_t topCur;

  assign ackTake = irqAck & irqReq_r;
  assign retTake = irqReturn & (|inSvc_r);

  // Highest level now in service
  always_comb begin
    topCur = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (inSvc_r[i]) topCur = 2'(i);
    end
  end

  // Return frees the top level, a taken vector marks its level
  always_comb begin
    inSvcNxt = inSvc_r;
    if (retTake) inSvcNxt[topCur] = 1'b0; // RULE_15
    if (ackTake) inSvcNxt[irqLevel_r] = 1'b1; // RULE_15
    busyNxt = |inSvcNxt;
    topNxt = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (inSvcNxt[i]) topNxt = 2'(i);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) inSvc_r <= 4'h0;
    else inSvc_r <= inSvcNxt;
  end

  // ----------------------------------------------------------------
  // Arbitration and vector
  // ----------------------------------------------------------------
  logic found;
  viep_level_t bestLvl;
  logic [3:0] bestIdx;
  logic [15:0] bestVec;

  // Highest level wins; only a strictly higher later source displaces
  always_comb begin
    found = 1'b0;
    bestLvl = 2'h0;
    bestIdx = 4'h0;
    for (int i = 0; i < NSRC; i++) begin
      if (srcElig[i] && (!found || srcLvl[i] > bestLvl)) begin // RULE_14
        found = 1'b1;
        bestLvl = srcLvl[i];
        bestIdx = 4'(i); // RULE_03
      end
    end
  end

  // Vector table in polling order
  always_comb begin
    case (viep_src_t'(bestIdx))
      VIEP_SRC_EXT0: bestVec = `VIEP_VEC_EXT0; // RULE_01
      VIEP_SRC_TIMER0: bestVec = `VIEP_VEC_TIMER0;
      VIEP_SRC_EXT1: bestVec = `VIEP_VEC_EXT1;
      VIEP_SRC_TIMER1: bestVec = `VIEP_VEC_TIMER1;
      VIEP_SRC_COUNTER: bestVec = `VIEP_VEC_COUNTER; // RULE_02
      VIEP_SRC_SERIAL: bestVec = `VIEP_VEC_SERIAL;
      VIEP_SRC_TIMER2: bestVec = `VIEP_VEC_TIMER2;
      VIEP_SRC_KEYPAD: bestVec = `VIEP_VEC_KEYPAD; // RULE_02
      VIEP_SRC_UNUSED: bestVec = `VIEP_VEC_UNUSED;
      VIEP_SRC_SPI: bestVec = `VIEP_VEC_SPI; // RULE_02
      default: bestVec = `VIEP_VEC_RESET;
    endcase
  end

  // Request to the core; vector and level hold while idle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irqReq_r <= 1'b0;
      irqVector_r <= `VIEP_VEC_RESET; // RULE_01
      irqLevel_r <= 2'h0;
    end else begin
      irqReq_r <= found;
      if (found) begin
        irqVector_r <= bestVec;
        irqLevel_r <= bestLvl;
      end
    end
  end

  assign irqReq = irqReq_r;
  assign irqVector = irqVector_r;
  assign irqLevel = irqLevel_r;

  // ----------------------------------------------------------------
  // Event status and mask
  // ----------------------------------------------------------------
  logic [7:0] evtSet;
  logic [7:0] evtClr;

  assign evtSet = {5'h00, retTake ? 1'b0 : irqReturn, ackTake & (|inSvc_r),
                   ackTake};
  assign evtClr = (regWr && regAddr == `VIEP_ADDR_EVT_STS) ? regWData : 8'h00;

  // Write one clears; a new event in the same cycle wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) evtSts_r <= `VIEP_RST_EVT;
    else evtSts_r <= ((evtSts_r & ~evtClr) | evtSet) & `VIEP_WMSK_EVT;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) evtMsk_r <= `VIEP_RST_EVT;
    else if (regWr && regAddr == `VIEP_ADDR_EVT_MSK)
      evtMsk_r <= regWData & `VIEP_WMSK_EVT;
  end

  assign evtIrq = |(evtSts_r & evtMsk_r);

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regRData_r <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `VIEP_ADDR_EN_MAIN: regRData_r <= enMain_r;
        `VIEP_ADDR_EN_EXTRA: regRData_r <= enExtra_r;
        `VIEP_ADDR_PRIO_HI: regRData_r <= prioHi_r; // RULE_09
        `VIEP_ADDR_PRIO_LO: regRData_r <= prioLo_r;
        `VIEP_ADDR_EVT_STS: regRData_r <= evtSts_r;
        `VIEP_ADDR_EVT_MSK: regRData_r <= evtMsk_r;
        default: regRData_r <= 8'h00;
      endcase
    end else begin
      regRData_r <= 8'h00;
    end
  end

  // Single-bit reads of the bit-accessible registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) bitRData_r <= 1'b0;
    else if (bitRd && bitAddr[7:3] == `VIEP_BITPG_EN_MAIN)
      bitRData_r <= enMain_r[bitIdx];
    else if (bitRd && bitAddr[7:3] == `VIEP_BITPG_PRIO_LO)
      bitRData_r <= prioLo_r[bitIdx];
    else bitRData_r <= 1'b0;
  end

  assign regRData = regRData_r;
  assign bitRData = bitRData_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic [3:0] lastWin_r;
  viep_level_t lastBest_r;
  logic ext0Tie_r;
  viep_level_t eligMax;

  // Highest eligible level, worked out apart from the arbiter
  always_comb begin
    eligMax = 2'h0;
    for (int i = 0; i < NSRC; i++) begin
      if (srcElig[i] && srcLvl[i] > eligMax) eligMax = srcLvl[i];
    end
  end

  always_ff @(posedge ref_clk) begin
    lastWin_r <= bestIdx;
    lastBest_r <= eligMax;
    ext0Tie_r <= srcElig[0] & (srcLvl[0] == bestLvl);
  end

  a_gate_blocks: assert property ( // RULE_04
    !enMain_r[`VIEP_GLOBAL_IRQ_GATE] |=> !irqReq)
    else $error("request passed with global gate clear");

  a_vec_ext0: assert property ( // RULE_01
    irqReq && lastWin_r == 4'h0 |-> irqVector == 16'h0003)
    else $error("external 0 vector wrong");

  a_vec_counter: assert property ( // RULE_02
    irqReq && lastWin_r == 4'h4 |-> irqVector == 16'h0033)
    else $error("counter array vector wrong");

  a_vec_unused: assert property ( // RULE_02
    irqReq |-> irqVector != 16'h0043 && irqVector[2:0] == 3'h3)
    else $error("vector unused or misaligned");

  a_poll_first: assert property ( // RULE_03
    irqReq && ext0Tie_r |-> lastWin_r == 4'h0)
    else $error("poll order not honoured");

  a_level_max: assert property ( // RULE_14
    irqReq |-> irqLevel == lastBest_r && irqLevel == $past(bestLvl))
    else $error("level of winner wrong");

  a_no_equal_preempt: assert property ( // RULE_13
    irqReq && (|inSvc_r) |-> irqLevel > topCur && !inSvc_r[3])
    else $error("preempt by equal or of top level");

  a_ack_marks: assert property ( // RULE_15
    irqAck && irqReq && !irqReturn |=> inSvc_r[$past(irqLevel)])
    else $error("taken level not marked in service");

  a_ret_release: assert property ( // RULE_15
    irqReturn && !irqAck && (|inSvc_r) |=>
      $countones(inSvc_r) == $countones($past(inSvc_r)) - 1)
    else $error("return did not free one level");

  a_reset_clear: assert property ( // RULE_10
    $rose(rst_n) |-> enMain_r == 8'h00 && prioHi_r[6:0] == 7'h00 &&
      prioLo_r[6:0] == 7'h00)
    else $error("registers not cleared by reset");

  a_hi_no_bitwr: assert property ( // RULE_12
    bitWr && !(regWr && regAddr == `VIEP_ADDR_PRIO_HI) |=>
      $stable(prioHi_r))
    else $error("high priority changed by bit access");

  a_extra_rsvd: assert property ( // RULE_06
    regRd && regAddr == `VIEP_ADDR_EN_EXTRA |=>
      regRData[7:3] == 5'h00 && regRData[1] == 1'b0)
    else $error("reserved extra enable bits not zero");

  c_nested: cover property (irqAck && irqReq && (|inSvc_r));
  c_counter_vec: cover property (irqReq && irqVector == 16'h0033);
  c_top_level: cover property (irqAck && irqReq && irqLevel == 2'h3);
  c_evt_irq: cover property ($rose(evtIrq));

endmodule : viep_ctrl

// [dv/viep_core_model.sv]
// Behavioural core that takes vectors and returns from them
`timescale 1ns/1ps
module viep_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Vector handshake
  input wire logic irqReq,
  output logic irqAck,
  output logic irqReturn,
  // Pacing set by the bench
  input wire logic [7:0] ackLat,
  input wire logic [7:0] svcLen,
  // Routines currently nested
  output logic [3:0] nestDepth
);
  logic [7:0] waitR;
  logic [7:0] svcR;

  // Ack after ackLat cycles of request, one return per svcLen+1 cycles
  always_ff @(posedge ref_clk) begin
    irqAck <= 1'b0;
    irqReturn <= 1'b0;
    if (!rst_n) begin
      waitR <= 8'h00;
      svcR <= 8'h00;
      nestDepth <= 4'h0;
    end else if (irqReq && !irqAck && waitR >= ackLat) begin
      irqAck <= 1'b1;
      waitR <= 8'h00;
      svcR <= 8'h00;
      nestDepth <= nestDepth + 4'h1;
    end else begin
      waitR <= (irqReq && !irqAck) ? waitR + 8'h01 : 8'h00;
      svcR <= svcR + 8'h01;
      if (nestDepth != 4'h0 && svcR >= svcLen) begin
        irqReturn <= 1'b1; // Leaves the innermost routine
        svcR <= 8'h00;
        nestDepth <= nestDepth - 4'h1;
      end
    end
  end
endmodule : viep_core_model

// [dv/tb.sv]
// Self-checking bench for the interrupt enable and priority block
`timescale 1ns/1ps
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin failCount++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic ref_clk, rst_n, regWr, regRd, bitWData, bitWr, bitRd, bitRData;
  logic [7:0] regAddr, regWData, regRData, bitAddr, ackLat, svcLen, lfsrR;
  logic [15:0] flags, irqVector;
  logic irqReq, irqAck, irqReturn, evtIrq;
  logic rdSeen = 1'b0;
  logic bitSeen = 1'b0;
  logic [1:0] irqLevel;
  logic [3:0] nestDepth;
  logic [7:0] rdQ[$];
  logic [7:0] expRd;
  logic [17:0] vecQ[$];
  logic [17:0] expVec;
  int failCount, testsRun;
  logic [15:0] vecTbl [16] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
    16'h0023, 16'h0023, 16'h002b, 16'h002b, 16'h0033, 16'h0033, 16'h0033,
    16'h0033, 16'h0033, 16'h0033, 16'h003b, 16'h004b};
  logic [15:0] enTbl [16] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
    16'h0010, 16'h0010, 16'h0020, 16'h0020, 16'h0040, 16'h0040, 16'h0040,
    16'h0040, 16'h0040, 16'h0040, 16'h0100, 16'h0400};
  logic [15:0] pollVec [9] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
    16'h0033, 16'h0023, 16'h002b, 16'h003b, 16'h004b};
  // Level in bits 17:16, vector below
  logic [17:0] lvlVec [4] = '{18'h3001b, 18'h20013, 18'h1000b, 18'h00003};
  logic [17:0] nestVec [5] = '{18'h00003, 18'h1000b, 18'h3001b, 18'h3002b,
    18'h00023};
  logic [7:0] regOff [4] = '{8'ha8, 8'hb1, 8'hb7, 8'hb8};
  logic [7:0] wrMsk [4] = '{8'hff, 8'hff, 8'h7f, 8'h7f};
  logic [7:0] rdMsk [4] = '{8'hff, 8'h05, 8'h7f, 8'h7f};

  // ----------------------------------------------------------------
  // Design and core model
  // ----------------------------------------------------------------
  viep_ctrl viep_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWData(regWData), .regWr(regWr), .regRd(regRd),
    .regRData(regRData), .bitAddr(bitAddr), .bitWData(bitWData),
    .bitWr(bitWr), .bitRd(bitRd), .bitRData(bitRData),
    .ext0RequestFlag(flags[0]), .timer0OverflowFlag(flags[1]),
    .ext1RequestFlag(flags[2]), .timer1OverflowFlag(flags[3]),
    .uartReceiveDone(flags[4]), .uartSendDone(flags[5]),
    .timer2OverflowFlag(flags[6]), .timer2ExternalFlag(flags[7]),
    .counterArrayOverflow(flags[8]), .counterChannelFlags(flags[13:9]),
    .keypadRequest(flags[14]), .spiRequest(flags[15]), .irqReq(irqReq),
    .irqVector(irqVector), .irqLevel(irqLevel), .irqAck(irqAck),
    .irqReturn(irqReturn), .evtIrq(evtIrq));
  viep_core_model viep_core_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .irqReq(irqReq), .irqAck(irqAck), .irqReturn(irqReturn),
    .ackLat(ackLat), .svcLen(svcLen), .nestDepth(nestDepth));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsrNext(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsrNext

  // Flags served by a given vector
  function automatic logic [15:0] maskOf(input logic [15:0] v);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      m[i] = (vecTbl[i] == v);
    end
    return m;
  endfunction : maskOf

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWData <= v;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
  endtask : rd

  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge ref_clk);
    bitAddr <= a;
    bitWData <= v;
    bitWr <= 1'b1;
    @(posedge ref_clk);
    bitWr <= 1'b0;
  endtask : bw

  task automatic br(input logic [7:0] a, input logic e);
    rdQ.push_back({7'h00, e});
    @(posedge ref_clk);
    bitAddr <= a;
    bitRd <= 1'b1;
    @(posedge ref_clk);
    bitRd <= 1'b0;
  endtask : br

  // Waits for the core to take a vector, then clears its flags
  task automatic waitAck();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!(irqAck === 1'b1 && irqReq === 1'b1) && n < 400);
    `CHK(n < 400, 1'b1)
    flags <= flags & ~maskOf(irqVector);
    @(posedge ref_clk);
  endtask : waitAck

  task automatic waitIdle();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (nestDepth !== 4'h0 && n < 400);
    repeat (2) @(posedge ref_clk);
  endtask : waitIdle

  task automatic printVerdict();
    $display("Checks %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : printVerdict

  // ----------------------------------------------------------------
  // Clock, monitor and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Compares read data and taken vectors against the oldest note
  always @(posedge ref_clk) begin
    if (rdSeen) begin
      expRd = rdQ.pop_front();
      `CHK(regRData, expRd)
    end
    if (bitSeen) begin
      expRd = rdQ.pop_front();
      `CHK({7'h00, bitRData}, expRd)
    end
    if ((irqAck && irqReq) === 1'b1) begin
      expVec = vecQ.pop_front();
      `CHK({irqLevel, irqVector}, expVec)
    end
    rdSeen <= regRd;
    bitSeen <= bitRd;
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    failCount++;
    printVerdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, regWr, regRd, bitWData, bitWr, bitRd} = '0;
    {regAddr, regWData, bitAddr, flags} = '0;
    ackLat = 8'h04;
    svcLen = 8'h04;
    lfsrR = 8'h5b;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Reset values, unmapped place, random write and read back
    for (int r = 0; r < 4; r++) rd(regOff[r], 8'h00);
    rd(8'he1, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    repeat (4) begin
      lfsrR = lfsrNext(lfsrR);
      for (int r = 0; r < 4; r++) begin
        wr(regOff[r], lfsrR & wrMsk[r]);
        rd(regOff[r], lfsrR & wrMsk[r] & rdMsk[r]);
      end
    end
    // Single-bit access
    wr(8'ha8, 8'h00);
    wr(8'hb7, 8'h00);
    wr(8'hb8, 8'h00);
    bw(8'haf, 1'b1);
    bw(8'hbc, 1'b1);
    bw(8'hb3, 1'b1);
    rd(8'ha8, 8'h80);
    rd(8'hb8, 8'h10);
    rd(8'hb7, 8'h00);
    br(8'hbc, 1'b1);
    wr(8'hb8, 8'h00);
    // Global gate closed blocks everything
    wr(8'ha8, 8'h7f);
    wr(8'hb1, 8'h05);
    flags <= 16'hffff;
    repeat (4) @(posedge ref_clk);
    `CHK(irqReq, 1'b0)
    flags <= 16'h0000;
    // Each flag alone: blocked by its own enable, then its vector
    for (int b = 0; b < 16; b++) begin
      ackLat <= b[0] ? 8'h07 : 8'h00;
      wr(8'ha8, 8'hff ^ enTbl[b][7:0]);
      wr(8'hb1, 8'h05 ^ enTbl[b][15:8]);
      flags <= 16'h0001 << b;
      repeat (4) @(posedge ref_clk);
      `CHK(irqReq, 1'b0)
      vecQ.push_back({2'h0, vecTbl[b]});
      if (b < 14) wr(8'ha8, 8'hff);
      else wr(8'hb1, 8'h05);
      waitAck();
      waitIdle();
    end
    // All at one level: polling order
    ackLat <= 8'h04;
    foreach (pollVec[i]) vecQ.push_back({2'h0, pollVec[i]});
    flags <= 16'hffff;
    repeat (9) waitAck();
    waitIdle();
    // Levels 0..3 together, then nesting and withholding
    svcLen <= 8'h28;
    wr(8'hb7, 8'h2c);
    wr(8'hb8, 8'h2a);
    foreach (lvlVec[i]) vecQ.push_back(lvlVec[i]);
    flags <= 16'h000f;
    repeat (4) waitAck();
    waitIdle();
    foreach (nestVec[i]) vecQ.push_back(nestVec[i]);
    flags <= 16'h0001;
    waitAck();
    flags <= flags | 16'h0010;
    repeat (5) @(posedge ref_clk);
    `CHK(irqReq, 1'b0)
    flags <= flags | 16'h0002;
    waitAck();
    flags <= flags | 16'h0008;
    waitAck();
    flags <= flags | 16'h0040;
    repeat (5) @(posedge ref_clk);
    `CHK(irqReq, 1'b0)
    waitAck();
    waitAck();
    waitIdle();
    // Event status, mask and clear
    rd(8'he1, 8'h03);
    wr(8'he2, 8'h04);
    @(negedge ref_clk);
    `CHK(evtIrq, 1'b0)
    wr(8'he2, 8'h02);
    @(negedge ref_clk);
    `CHK(evtIrq, 1'b1)
    wr(8'he1, 8'h03);
    @(negedge ref_clk);
    `CHK(evtIrq, 1'b0)
    rd(8'he1, 8'h00);
    // Second reset in mid-run
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'ha8, 8'h00);
    rd(8'hb7, 8'h00);
    repeat (3) @(posedge ref_clk);
    printVerdict();
  end
endmodule : tb
